// file: meim_pkg.sv
/*
 * meim_pkg: register map, field positions and reset values of the metering
 * event interrupt mask block.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package meim_pkg;
    // register byte offsets
    localparam logic [7:0]  MEIM_OFF_MASK      = 8'h00;
    localparam logic [7:0]  MEIM_OFF_STATUS    = 8'h04;
    localparam logic [7:0]  MEIM_OFF_ACCUMULATION_MODE_REG   = 8'h08;
    localparam logic [7:0]  MEIM_OFF_PULSE_MODE_REG    = 8'h0C;
    localparam logic [7:0]  MEIM_OFF_HALF_LINE_CYCLE_COUNT   = 8'h10;
    localparam logic [7:0]  MEIM_OFF_LCCOUNT   = 8'h14;

    // event and enable bit positions, shared by mask and status
    localparam int MEIM_EV_W         = 18;
    localparam int MEIM_B_TOT_HF     = 0;
    localparam int MEIM_B_FACT_HF    = 1;
    localparam int MEIM_B_RSVD       = 2;
    localparam int MEIM_B_FREA_HF    = 3;
    localparam int MEIM_B_APP_HF     = 4;
    localparam int MEIM_B_LINE_DONE  = 5;
    localparam int MEIM_B_ACT_SIGN   = 6;
    localparam int MEIM_B_SUM1_SIGN  = 9;
    localparam int MEIM_B_REA_SIGN   = 10;
    localparam int MEIM_B_SUM2_SIGN  = 13;
    localparam int MEIM_B_PULSE      = 14;
    localparam int MEIM_B_DSP_DONE   = 17;

    // accumulation mode register
    localparam int MEIM_ACC_REVSEL   = 6;
    // pulse mode register: select fields then disable bits
    localparam int MEIM_CF_SEL_W     = 3;
    localparam int MEIM_CF_DIS_LSB   = 9;
    localparam int MEIM_CF_W         = 12;
    // line-cycle control register
    localparam int MEIM_LC_CNT_W     = 16;
    localparam int MEIM_LC_MODE_BIT  = 16;

    // change detector input layout
    localparam int MEIM_DET_W        = 23;
    localparam int MEIM_D_TOT        = 0;
    localparam int MEIM_D_FACT       = 3;
    localparam int MEIM_D_FREA       = 6;
    localparam int MEIM_D_APP        = 9;
    localparam int MEIM_D_ACT        = 12;
    localparam int MEIM_D_REA        = 15;
    localparam int MEIM_D_SUM        = 18;
    localparam int MEIM_D_PULSE      = 20;

    // reset values
    localparam logic [MEIM_EV_W-1:0]     MEIM_MASK_RST    = 18'h00000;
    localparam logic [MEIM_EV_W-1:0]     MEIM_STATUS_RST  = 18'h00000;
    localparam logic [MEIM_CF_W-1:0]     MEIM_PULSE_MODE_REG_RST  = 12'h000;
    localparam logic [MEIM_LC_CNT_W-1:0] MEIM_HALF_LINE_CYCLE_COUNT_RST = 16'h0000;
    localparam logic [31:0]              MEIM_RD_UNMAPPED = 32'h00000000;
endpackage

// file: meim_reg_if.sv
/*
 * meim_reg_if: register access strobes between the bus slave and the core.
 * Assumes both ends run on the same clock; wr_stb is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
interface meim_reg_if;
    logic        wr_stb;
    logic [7:0]  addr;
    logic [3:0]  sel;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport bus  (output wr_stb, output addr, output sel, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input sel, input wdata, output rdata);
endinterface
`default_nettype wire

// file: meim_chg_det.sv
/*
 * meim_chg_det: per-bit change and falling-edge detection.
 * Assumes inputs synchronous to clk_i; no event in the first cycle after reset.
 */
`timescale 1ns/1ps
`default_nettype none
module meim_chg_det
    import meim_pkg::*;
#(
    parameter int W = MEIM_DET_W
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // sampled levels
    input  wire logic [W-1:0] d_i,
    // one-cycle events
    output logic      [W-1:0] chg_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] prev_ff;
    logic         valid_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff  <= '0;
            valid_ff <= 1'b0;
        end else begin
            prev_ff  <= d_i;
            valid_ff <= 1'b1;
        end
    end

    // the reset value of prev_ff is not a real sample, so it must not fire
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign chg_o[g]  = valid_ff & (d_i[g] ^ prev_ff[g]);
            assign fall_o[g] = valid_ff & prev_ff[g] & ~d_i[g];
        end
    endgenerate
endmodule
`default_nettype wire

// file: meim_wb_slave.sv
/*
 * meim_wb_slave: classic Wishbone slave turning bus cycles into strobes.
 * Assumes a master that holds its request until ack; ack comes one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module meim_wb_slave (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // wishbone
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // register side
    meim_reg_if.bus          rif
);
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        req;

    // ack_ff in the term keeps a held request from acting twice
    assign req        = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign rif.wr_stb = req & wb_we_i;
    assign rif.addr   = wb_adr_i;
    assign rif.sel    = wb_sel_i;
    assign rif.wdata  = wb_dat_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h00000000;
        end else if (req & ~wb_we_i) begin
            dat_ff <= rif.rdata;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
endmodule
`default_nettype wire

// file: meim_top.sv
/*
 * meim_top: first-group metering event flags, enable mask and active-low
 * interrupt request, plus pulse-pin gating and select fields.
 * Assumes all event inputs are synchronous to clk_i (25 MHz) and that the
 * energy, sign and pulse sources sit outside this block.
 */
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module meim_top
    import meim_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone register bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // energy accumulator bit 30, one bit per phase A..C
    input  wire logic [2:0]  tot_active_b30_i,
    input  wire logic [2:0]  fund_active_b30_i,
    input  wire logic [2:0]  fund_reactive_b30_i,
    input  wire logic [2:0]  apparent_b30_i,
    // line-cycle accumulation
    input  wire logic        half_cycle_i,
    // power signs, high when negative
    input  wire logic [2:0]  tot_active_neg_i,
    input  wire logic [2:0]  fund_active_neg_i,
    input  wire logic [2:0]  fund_reactive_neg_i,
    input  wire logic [1:0]  path_sum_neg_i,
    // raw pulse generator levels, active low
    input  wire logic [2:0]  pulse_raw_n_i,
    // periodic computation done pulse
    input  wire logic        dsp_cycle_done_i,
    // interrupt
    output logic             interrupt_request_n_o,
    // pulse pins, active low
    output logic             energy_pulse_out_one_o,
    output logic             energy_pulse_out_two_o,
    output logic             energy_pulse_out_three_o,
    // power selects to the pulse datapaths
    output logic [2:0]       pulse_one_power_select_o,
    output logic [2:0]       pulse_two_power_select_o,
    output logic [2:0]       pulse_three_power_select_o,
    output logic             reverse_power_source_select_o
);
    meim_reg_if rif ();

    logic [MEIM_EV_W-1:0]     mask_ff;
    logic [MEIM_EV_W-1:0]     status_ff;
    logic [MEIM_EV_W-1:0]     nxt_status;
    logic [MEIM_EV_W-1:0]     ev;
    logic [MEIM_EV_W-1:0]     clr;
    logic                     revsel_ff;
    logic [MEIM_CF_W-1:0]     pulse_mode_reg_ff;
    logic [MEIM_LC_CNT_W-1:0] lc_count_ff;
    logic                     lc_mode_ff;
    logic [MEIM_LC_CNT_W-1:0] lc_cnt_ff;
    logic                     lc_done;
    logic                     irq_n_ff;
    logic [2:0]               pin_ff;
    logic [2:0]               act_sel_neg;
    logic [MEIM_DET_W-1:0]    det_d;
    logic [MEIM_DET_W-1:0]    det_chg;
    logic [MEIM_DET_W-1:0]    det_fall;
    logic [31:0]              wmask;

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic wr_hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
        wr_hit = stb & (a[7:2] == off[7:2]);
    endfunction

    meim_wb_slave u_wb (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .rif      (rif.bus)
    );

    assign wmask = byte_mask(rif.sel);

    // a select switch may itself look like a sign change; accepted as real
    assign act_sel_neg = revsel_ff ? fund_active_neg_i : tot_active_neg_i;

    assign det_d = {pulse_raw_n_i, path_sum_neg_i, fund_reactive_neg_i, act_sel_neg,
                    apparent_b30_i, fund_reactive_b30_i, fund_active_b30_i, tot_active_b30_i};

    meim_chg_det #(.W(MEIM_DET_W)) u_det (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (det_d),
        .chg_o  (det_chg),
        .fall_o (det_fall)
    );

    always_comb begin
        ev                   = '0;
        ev[MEIM_B_TOT_HF]    = |det_chg[MEIM_D_TOT +: 3];
        ev[MEIM_B_FACT_HF]   = |det_chg[MEIM_D_FACT +: 3];
        ev[MEIM_B_RSVD]      = 1'b0;
        ev[MEIM_B_FREA_HF]   = |det_chg[MEIM_D_FREA +: 3];
        ev[MEIM_B_APP_HF]    = |det_chg[MEIM_D_APP +: 3];
        ev[MEIM_B_LINE_DONE] = lc_done;
        ev[MEIM_B_ACT_SIGN +: 3] = det_chg[MEIM_D_ACT +: 3];
        ev[MEIM_B_SUM1_SIGN] = det_chg[MEIM_D_SUM];
        ev[MEIM_B_SUM2_SIGN] = det_chg[MEIM_D_SUM + 1];
        ev[MEIM_B_REA_SIGN +: 3] = det_chg[MEIM_D_REA +: 3];
        // raw levels are taken before the pin gate, so disable does not hide them
        ev[MEIM_B_PULSE +: 3] = det_fall[MEIM_D_PULSE +: 3];
        ev[MEIM_B_DSP_DONE]  = dsp_cycle_done_i;
    end

    // status clears are write-one; an event in the same cycle wins
    assign clr = wr_hit(rif.wr_stb, rif.addr, MEIM_OFF_STATUS) ?
                 (rif.wdata[MEIM_EV_W-1:0] & wmask[MEIM_EV_W-1:0]) : '0;
    assign nxt_status = (status_ff & ~clr) | ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= MEIM_STATUS_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= MEIM_MASK_RST;
        end else if (wr_hit(rif.wr_stb, rif.addr, MEIM_OFF_MASK)) begin
            mask_ff <= ((mask_ff & ~wmask[MEIM_EV_W-1:0]) | (rif.wdata[MEIM_EV_W-1:0] & wmask[MEIM_EV_W-1:0]))
                       & ~(18'h00001 << MEIM_B_RSVD);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            revsel_ff <= 1'b0;
        end else if (wr_hit(rif.wr_stb, rif.addr, MEIM_OFF_ACCUMULATION_MODE_REG) & rif.sel[0]) begin
            revsel_ff <= rif.wdata[MEIM_ACC_REVSEL];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_mode_reg_ff <= MEIM_PULSE_MODE_REG_RST;
        end else if (wr_hit(rif.wr_stb, rif.addr, MEIM_OFF_PULSE_MODE_REG)) begin
            pulse_mode_reg_ff <= (pulse_mode_reg_ff & ~wmask[MEIM_CF_W-1:0]) | (rif.wdata[MEIM_CF_W-1:0] & wmask[MEIM_CF_W-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lc_count_ff <= MEIM_HALF_LINE_CYCLE_COUNT_RST;
            lc_mode_ff  <= 1'b0;
        end else if (wr_hit(rif.wr_stb, rif.addr, MEIM_OFF_HALF_LINE_CYCLE_COUNT)) begin
            lc_count_ff <= (lc_count_ff & ~wmask[MEIM_LC_CNT_W-1:0])
                           | (rif.wdata[MEIM_LC_CNT_W-1:0] & wmask[MEIM_LC_CNT_W-1:0]);
            if (rif.sel[2]) begin
                lc_mode_ff <= rif.wdata[MEIM_LC_MODE_BIT];
            end
        end
    end

    // a count of zero never completes, so a half-set mode cannot flood the host
    assign lc_done = lc_mode_ff & half_cycle_i & (lc_count_ff != '0)
                     & (({1'b0, lc_cnt_ff} + 17'h00001) >= {1'b0, lc_count_ff});

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lc_cnt_ff <= '0;
        end else if (~lc_mode_ff | wr_hit(rif.wr_stb, rif.addr, MEIM_OFF_HALF_LINE_CYCLE_COUNT) | lc_done) begin
            lc_cnt_ff <= '0;
        end else if (half_cycle_i) begin
            lc_cnt_ff <= lc_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= ~|(status_ff & mask_ff);
        end
    end

    // disabled pins idle high; the interrupt path never looks at these flops
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_pin
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_ff[p] <= 1'b1;
                end else begin
                    pin_ff[p] <= pulse_mode_reg_ff[MEIM_CF_DIS_LSB + p] | pulse_raw_n_i[p];
                end
            end
        end
    endgenerate

    always_comb begin
        case (rif.addr[7:2])
            MEIM_OFF_MASK[7:2]:    rif.rdata = {14'h0000, mask_ff};
            MEIM_OFF_STATUS[7:2]:  rif.rdata = {14'h0000, status_ff};
            MEIM_OFF_ACCUMULATION_MODE_REG[7:2]: rif.rdata = {25'h0000000, revsel_ff, 6'h00};
            MEIM_OFF_PULSE_MODE_REG[7:2]:  rif.rdata = {20'h00000, pulse_mode_reg_ff};
            MEIM_OFF_HALF_LINE_CYCLE_COUNT[7:2]: rif.rdata = {15'h0000, lc_mode_ff, lc_count_ff};
            MEIM_OFF_LCCOUNT[7:2]: rif.rdata = {16'h0000, lc_cnt_ff};
            default:               rif.rdata = MEIM_RD_UNMAPPED;
        endcase
    end

    assign interrupt_request_n_o         = irq_n_ff;
    assign energy_pulse_out_one_o        = pin_ff[0];
    assign energy_pulse_out_two_o        = pin_ff[1];
    assign energy_pulse_out_three_o      = pin_ff[2];
    assign pulse_one_power_select_o      = pulse_mode_reg_ff[0 +: MEIM_CF_SEL_W];
    assign pulse_two_power_select_o      = pulse_mode_reg_ff[3 +: MEIM_CF_SEL_W];
    assign pulse_three_power_select_o    = pulse_mode_reg_ff[6 +: MEIM_CF_SEL_W];
    assign reverse_power_source_select_o = revsel_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    irq_low_a: assert property (|(status_ff & mask_ff) |=> !interrupt_request_n_o)
        else $error("enabled pending flag did not pull the request low");
    irq_high_a: assert property (!(|(status_ff & mask_ff)) |=> interrupt_request_n_o)
        else $error("request low without an enabled flag");
    rsvd_bit_a: assert property (!mask_ff[MEIM_B_RSVD] && !status_ff[MEIM_B_RSVD])
        else $error("reserved bit took a value");
    tot_energy_a: assert property (!$past(rst_i) && (tot_active_b30_i != $past(tot_active_b30_i))
                                   |=> status_ff[MEIM_B_TOT_HF])
        else $error("total active bit 30 change missed");
    fact_energy_a: assert property (!$past(rst_i) && (fund_active_b30_i != $past(fund_active_b30_i))
                                    |=> status_ff[MEIM_B_FACT_HF])
        else $error("fundamental active bit 30 change missed");
    app_energy_a: assert property (!$past(rst_i) && (apparent_b30_i != $past(apparent_b30_i))
                                   |=> status_ff[MEIM_B_APP_HF])
        else $error("apparent bit 30 change missed");
    line_done_a: assert property (lc_done |=> status_ff[MEIM_B_LINE_DONE] && lc_cnt_ff == '0)
        else $error("line-cycle completion not flagged");
    pulse_fall_a: assert property (!$past(rst_i) && $past(pulse_raw_n_i[0]) && !pulse_raw_n_i[0]
                                   |=> status_ff[MEIM_B_PULSE])
        else $error("pulse one falling edge missed");
    pin_disable_a: assert property (pulse_mode_reg_ff[MEIM_CF_DIS_LSB + 1] |=> energy_pulse_out_two_o)
        else $error("disabled pulse pin went low");
    dsp_done_a: assert property (dsp_cycle_done_i |=> status_ff[MEIM_B_DSP_DONE])
        else $error("computation done not flagged");
    frea_energy_a: assert property (!$past(rst_i) && (fund_reactive_b30_i != $past(fund_reactive_b30_i))
                                    |=> status_ff[MEIM_B_FREA_HF])
        else $error("fundamental reactive bit 30 change missed");
    act_sign_a: assert property (!$past(rst_i) && (act_sel_neg[1] != $past(act_sel_neg[1]))
                                 |=> status_ff[MEIM_B_ACT_SIGN + 1])
        else $error("phase B active sign change missed");
    sum_sign_a: assert property (!$past(rst_i) && (path_sum_neg_i[1] != $past(path_sum_neg_i[1]))
                                 |=> status_ff[MEIM_B_SUM2_SIGN])
        else $error("path two sum sign change missed");
    rea_sign_a: assert property (!$past(rst_i) && (fund_reactive_neg_i[0] != $past(fund_reactive_neg_i[0]))
                                 |=> status_ff[MEIM_B_REA_SIGN])
        else $error("phase A reactive sign change missed");
    status_clr_a: assert property (##1 ((status_ff & $past(clr) & ~$past(ev)) == '0))
        else $error("cleared flag stayed set without an event");
    flag_sticky_a: assert property (##1 ((($past(status_ff) & ~$past(clr)) & ~status_ff) == '0))
        else $error("flag dropped without a clear");

    irq_seen_c: cover property (interrupt_request_n_o ##1 !interrupt_request_n_o);
    line_done_c: cover property (lc_done);
    clr_race_c: cover property (|(clr & ev));
    pulse_off_c: cover property (pulse_mode_reg_ff[MEIM_CF_DIS_LSB] && ev[MEIM_B_PULSE]);
    sum_sign_c: cover property (ev[MEIM_B_SUM2_SIGN] && mask_ff[MEIM_B_SUM2_SIGN]);
endmodule
`default_nettype wire

// file: tb_top.sv
/*
 * tb_top: self-checking bench for meim_top, driven over classic Wishbone.
 * Assumes ack one cycle after a request is taken, status visible one cycle after an event
 * and the request output one cycle after that; no separate far-side model.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import meim_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [2:0]  tot_active_b30_i = 3'h0;
    logic [2:0]  fund_active_b30_i = 3'h0;
    logic [2:0]  fund_reactive_b30_i = 3'h0;
    logic [2:0]  apparent_b30_i = 3'h0;
    logic        half_cycle_i = 1'b0;
    logic [2:0]  tot_active_neg_i = 3'h0;
    logic [2:0]  fund_active_neg_i = 3'h0;
    logic [2:0]  fund_reactive_neg_i = 3'h0;
    logic [1:0]  path_sum_neg_i = 2'h0;
    logic [2:0]  pulse_raw_n_i = 3'h7;
    logic        dsp_cycle_done_i = 1'b0;
    logic        interrupt_request_n_o;
    logic        energy_pulse_out_one_o;
    logic        energy_pulse_out_two_o;
    logic        energy_pulse_out_three_o;
    logic [2:0]  pulse_one_power_select_o;
    logic [2:0]  pulse_two_power_select_o;
    logic [2:0]  pulse_three_power_select_o;
    logic        reverse_power_source_select_o;
    logic [3:0]  be = 4'hF;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          ev[16] = '{0, 1, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17};

    meim_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .tot_active_b30_i, .fund_active_b30_i, .fund_reactive_b30_i,
        .apparent_b30_i, .half_cycle_i, .tot_active_neg_i, .fund_active_neg_i, .fund_reactive_neg_i,
        .path_sum_neg_i, .pulse_raw_n_i, .dsp_cycle_done_i, .interrupt_request_n_o,
        .energy_pulse_out_one_o, .energy_pulse_out_two_o, .energy_pulse_out_three_o,
        .pulse_one_power_select_o, .pulse_two_power_select_o, .pulse_three_power_select_o,
        .reverse_power_source_select_o);

    always #20 clk_i = ~clk_i;

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h00000000, got}, {31'h00000000, exp});
    endtask

    // request held until the edge that samples ack; data taken at that edge
    // only the watchdog ends a wait for ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= be;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        chk32(r, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one event per flag position, phases varied across sources
    task automatic fire(input int b);
        @(posedge clk_i);
        case (b)
            0: tot_active_b30_i <= tot_active_b30_i ^ 3'h2;
            1: fund_active_b30_i <= fund_active_b30_i ^ 3'h4;
            3: fund_reactive_b30_i <= fund_reactive_b30_i ^ 3'h1;
            4: apparent_b30_i <= apparent_b30_i ^ 3'h2;
            5: half_cycle_i <= 1'b1;
            6, 7, 8: tot_active_neg_i[b-6] <= ~tot_active_neg_i[b-6];
            9: path_sum_neg_i[0] <= ~path_sum_neg_i[0];
            10, 11, 12: fund_reactive_neg_i[b-10] <= ~fund_reactive_neg_i[b-10];
            13: path_sum_neg_i[1] <= ~path_sum_neg_i[1];
            14, 15, 16: pulse_raw_n_i[b-14] <= 1'b0;
            default: dsp_cycle_done_i <= 1'b1;
        endcase
        @(posedge clk_i);
        pulse_raw_n_i    <= 3'h7;
        dsp_cycle_done_i <= 1'b0;
        half_cycle_i     <= 1'b0;
    endtask

    initial begin
        #(40 * 20000);
        error_cnt++;
        print_verdict();
    end

    initial begin
        idle(8);
        rst_i <= 1'b0;
        idle(2);
        chk1(interrupt_request_n_o, 1'b1);
        for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h00000000);
        wr(8'h18, 32'hFFFFFFFF);
        rd_chk(8'h18, MEIM_RD_UNMAPPED);
        wr(MEIM_OFF_MASK, 32'hFFFFFFFF);
        rd_chk(MEIM_OFF_MASK, 32'h0003FFFB);
        // pins disabled during the sweep; pulse flags must still set
        wr(MEIM_OFF_PULSE_MODE_REG, 32'h00000FD1);
        foreach (ev[k]) begin
            wr(MEIM_OFF_MASK, 32'h0003FFFF ^ (32'h1 << ev[k]));
            fire(ev[k]);
            idle(3);
            rd_chk(MEIM_OFF_STATUS, 32'h1 << ev[k]);
            chk1(interrupt_request_n_o, 1'b1);
            chk32({29'h0, energy_pulse_out_three_o, energy_pulse_out_two_o, energy_pulse_out_one_o}, 32'h7);
            wr(MEIM_OFF_MASK, 32'h1 << ev[k]);
            idle(3);
            chk1(interrupt_request_n_o, 1'b0);
            wr(MEIM_OFF_STATUS, 32'h1 << ev[k]);
            idle(3);
            chk1(interrupt_request_n_o, 1'b1);
            rd_chk(MEIM_OFF_STATUS, 32'h00000000);
        end
        rd_chk(MEIM_OFF_PULSE_MODE_REG, 32'h00000FD1);
        chk32({23'h0, pulse_three_power_select_o, pulse_two_power_select_o, pulse_one_power_select_o},
              32'h000001D1);
        // pins enabled again: raw lows now reach them
        wr(MEIM_OFF_PULSE_MODE_REG, 32'h000001D1);
        @(posedge clk_i);
        pulse_raw_n_i <= 3'h0;
        idle(3);
        chk32({29'h0, energy_pulse_out_three_o, energy_pulse_out_two_o, energy_pulse_out_one_o}, 32'h0);
        pulse_raw_n_i <= 3'h7;
        rd_chk(MEIM_OFF_STATUS, 32'h0001C000);
        // fundamental source selected: total sign changes no longer count
        wr(MEIM_OFF_ACCUMULATION_MODE_REG, 32'h00000040);
        rd_chk(MEIM_OFF_ACCUMULATION_MODE_REG, 32'h00000040);
        chk1(reverse_power_source_select_o, 1'b1);
        idle(3);
        wr(MEIM_OFF_STATUS, 32'h0003FFFF);
        @(posedge clk_i);
        tot_active_neg_i <= ~tot_active_neg_i;
        idle(3);
        rd_chk(MEIM_OFF_STATUS, 32'h00000000);
        @(posedge clk_i);
        fund_active_neg_i[2] <= 1'b1;
        idle(3);
        rd_chk(MEIM_OFF_STATUS, 32'h00000100);
        wr(MEIM_OFF_STATUS, 32'h0003FFFF);
        // line-cycle mode, three half cycles
        wr(MEIM_OFF_HALF_LINE_CYCLE_COUNT, 32'h00010003);
        wr(MEIM_OFF_MASK, 32'h00000020);
        fire(5);
        fire(5);
        idle(2);
        rd_chk(MEIM_OFF_LCCOUNT, 32'h00000002);
        rd_chk(MEIM_OFF_STATUS, 32'h00000000);
        fire(5);
        idle(3);
        rd_chk(MEIM_OFF_STATUS, 32'h00000020);
        rd_chk(MEIM_OFF_LCCOUNT, 32'h00000000);
        chk1(interrupt_request_n_o, 1'b0);
        // byte lane 1 only: the other mask bytes keep their value
        wr(MEIM_OFF_MASK, 32'h0003FFFF);
        be = 4'h2;
        wr(MEIM_OFF_MASK, 32'h00000000);
        be = 4'hF;
        rd_chk(MEIM_OFF_MASK, 32'h000300FB);
        print_verdict();
    end
endmodule
`default_nettype wire
